//--- common/waea_pkg.sv
/*
  Constants, mode codes and state encoding of the word-alterable
  memory access block.
  Assumes a 40 MHz system clock and a host that keeps its own timing duties.
*/
package waea_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int WORDS  = 64;
  localparam int CNT_W  = 22;

  // alteration cycle lengths in milliseconds
  localparam int ALTER_TIME_STD_MS = 50;
  localparam int ALTER_TIME_HR_MS  = 100;
  localparam int ALTER_CYC_STD = ALTER_TIME_STD_MS * (CLK_HZ / 1000);
  localparam int ALTER_CYC_HR  = ALTER_TIME_HR_MS * (CLK_HZ / 1000);

  // read access time in nanoseconds, only the standard time is converted to cycles
  localparam int ACC_TIME_STD_NS = 2000;
  localparam int ACC_TIME_EXT_NS = 4000;
  localparam int ACC_CYC_STD = ACC_TIME_STD_NS * (CLK_HZ / 1_000_000) / 1000;

  // content of a freshly erased word
  localparam logic [DATA_W-1:0] ERASED_FILL = 8'h00;

  // decoded mode: mode two is masked while mode one is high
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_READ  = 2'h2;

  // index of each line in the edge detector
  localparam int LN_SEL  = 0;
  localparam int LN_C1   = 1;
  localparam int LN_C2   = 2;
  localparam int LN_CLK  = 3;
  localparam int LINES   = 4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ALTER = 4'h2,
    ST_RWAIT = 4'h4,
    ST_HOLD  = 4'h8
  } waea_state_t;

endpackage : waea_pkg

//--- hw/waea_word.sv
/*
  One stored word with its valid flag.
  Assumes the caller raises at most one of erase and write at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module waea_word (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       erase_en,
  input  wire logic                       write_en,
  input  wire logic [waea_pkg::DATA_W-1:0] wdata,
  output logic      [waea_pkg::DATA_W-1:0] word_q,
  output logic                            valid_q
);

  logic [waea_pkg::DATA_W-1:0] word_d;
  logic                        valid_d;

  // erase clears the cell, write loads it
  always_comb begin
    word_d  = word_q;
    valid_d = valid_q;
    if (erase_en) begin
      word_d  = waea_pkg::ERASED_FILL;
      valid_d = 1'b0;
    end else if (write_en) begin
      word_d  = wdata;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_q  <= waea_pkg::ERASED_FILL;
      valid_q <= 1'b0;
    end else begin
      word_q  <= word_d;
      valid_q <= valid_d;
    end
  end

endmodule : waea_word
`default_nettype wire

//--- hw/waea_top.sv
/*
  Access logic of a 64 by 8 word-alterable memory: select decode, mode
  decode, edge arming, timed erase and write, timed read with held output.
  Assumes all pins synchronous to clk; the data bus wire is resolved
  outside from data_out and data_oe_n.
  Assumes the host holds the mode for the whole alteration cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module waea_top #(
  parameter int ALTER_CYC = waea_pkg::ALTER_CYC_STD
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        cs_hi,
  input  wire logic                        cs_lo_n,
  input  wire logic                        mode_c1,
  input  wire logic                        mode_c2,
  input  wire logic                        rd_clk,
  input  wire logic [waea_pkg::ADDR_W-1:0] addr,
  input  wire logic [waea_pkg::DATA_W-1:0] data_in,
  output logic      [waea_pkg::DATA_W-1:0] data_out,
  output logic                             data_oe_n,
  output logic                             power_down,
  output logic                             alter_busy,
  output logic                             data_undef
);

  localparam logic [waea_pkg::CNT_W-1:0] ALTER_LAST =
    waea_pkg::CNT_W'(ALTER_CYC - 1);
  localparam logic [waea_pkg::CNT_W-1:0] ACC_LAST =
    waea_pkg::CNT_W'(waea_pkg::ACC_CYC_STD - 1);

  waea_pkg::waea_state_t            state_q, state_d;
  logic [waea_pkg::CNT_W-1:0]       cnt_q, cnt_d;
  logic [waea_pkg::LINES-1:0]       prev_q, lines_now;
  logic                             armed_q, armed_d;
  logic [1:0]                       op_mode_q, op_mode_d;
  logic [waea_pkg::ADDR_W-1:0]      op_addr_q, op_addr_d;
  logic [waea_pkg::DATA_W-1:0]      op_data_q, op_data_d;
  logic [waea_pkg::DATA_W-1:0]      dout_q, dout_d;
  logic                             oe_n_q, oe_n_d;
  logic                             undef_q, undef_d;
  logic                             pd_q, busy_q;
  logic                             pd_d, busy_d;
  logic                             sel, any_edge, rd_rise, commit;
  logic [1:0]                       mode_now;

  logic [waea_pkg::DATA_W-1:0]      word_q [waea_pkg::WORDS];
  logic [waea_pkg::WORDS-1:0]       valid_q;

  // select and mode decode
  assign sel      = cs_hi & ~cs_lo_n;
  assign mode_now = {mode_c1, mode_c2 & ~mode_c1};

  // decoded select and raw mode and read pulse levels watched for edges
  always_comb begin
    lines_now                   = '0;
    lines_now[waea_pkg::LN_SEL] = sel;
    lines_now[waea_pkg::LN_C1]  = mode_c1;
    lines_now[waea_pkg::LN_C2]  = mode_c2;
    lines_now[waea_pkg::LN_CLK] = rd_clk;
  end

  // edge on decoded select, either mode line or the read pulse arms the next alteration
  // raw mode two counts too, though a read ignores its level
  assign any_edge = |(lines_now ^ prev_q);
  assign rd_rise  = rd_clk & ~prev_q[waea_pkg::LN_CLK];

  // main sequencer
  // one operation at a time; abort and alteration completion fall back to idle, a read completes into hold
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    armed_d   = armed_q | any_edge;
    op_mode_d = op_mode_q;
    op_addr_d = op_addr_q;
    op_data_d = op_data_q;
    dout_d    = dout_q;
    undef_d   = undef_q;
    commit    = 1'b0;
    case (state_q)
      waea_pkg::ST_IDLE: begin
        // a read needs a fresh rising pulse, an alteration an armed edge
        if (sel && mode_c1 && rd_rise) begin
          state_d   = waea_pkg::ST_RWAIT;
          cnt_d     = '0;
          op_mode_d = mode_now;
          op_addr_d = addr;
          armed_d   = 1'b0;
        end else if (sel && !mode_c1 && armed_d) begin
          state_d   = waea_pkg::ST_ALTER;
          cnt_d     = '0;
          op_mode_d = mode_now;
          op_addr_d = addr;
          op_data_d = data_in;
          armed_d   = 1'b0;
        end
      end
      waea_pkg::ST_ALTER: begin
        if (!sel || mode_now != op_mode_q) begin
          // abort drops the cycle, the word keeps its value
          state_d = waea_pkg::ST_IDLE;
        end else if (cnt_q == ALTER_LAST) begin
          state_d = waea_pkg::ST_IDLE;
          commit  = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      waea_pkg::ST_RWAIT: begin
        if (!sel || mode_now != op_mode_q) begin
          state_d = waea_pkg::ST_IDLE;
        end else if (cnt_q == ACC_LAST) begin
          // sampled once here; later address changes are not tracked
          state_d = waea_pkg::ST_HOLD;
          dout_d  = word_q[op_addr_q];
          undef_d = ~valid_q[op_addr_q];
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      waea_pkg::ST_HOLD: begin
        if (!sel || mode_now != op_mode_q) begin
          state_d = waea_pkg::ST_IDLE;
        end else if (rd_rise) begin
          // a new pulse restarts the wait, old data stays driven
          state_d   = waea_pkg::ST_RWAIT;
          cnt_d     = '0;
          op_addr_d = addr;
          armed_d   = 1'b0;
        end
      end
      default: begin
        state_d = waea_pkg::ST_IDLE;
      end
    endcase
  end

  // output enable follows the sequencer
  always_comb begin
    if (!sel) begin
      oe_n_d = 1'b1;
    end else if (state_d == waea_pkg::ST_HOLD) begin
      oe_n_d = 1'b0;
    end else if (state_d == waea_pkg::ST_RWAIT) begin
      oe_n_d = oe_n_q;
    end else begin
      oe_n_d = 1'b1;
    end
  end

  // pin status flags: low power while deselected, busy while timing an alteration
  always_comb begin
    pd_d   = ~sel;
    busy_d = (state_d == waea_pkg::ST_ALTER);
  end

  // pin-facing flags, each straight from a flip-flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_n_q <= 1'b1;
      pd_q   <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      oe_n_q <= oe_n_d;
      pd_q   <= pd_d;
      busy_q <= busy_d;
    end
  end

  // sequencer registers; armed out of reset so no edge is needed at start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= waea_pkg::ST_IDLE;
      cnt_q     <= '0;
      prev_q    <= '0;
      armed_q   <= 1'b1;
      op_mode_q <= waea_pkg::MODE_WRITE;
      op_addr_q <= '0;
      op_data_q <= '0;
      dout_q    <= '0;
      undef_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      prev_q    <= lines_now;
      armed_q   <= armed_d;
      op_mode_q <= op_mode_d;
      op_addr_q <= op_addr_d;
      op_data_q <= op_data_d;
      dout_q    <= dout_d;
      undef_q   <= undef_d;
    end
  end

  // word array, one cell per address
  // only the cell at the latched address sees the commit strobe
  genvar gi;
  generate
    for (gi = 0; gi < waea_pkg::WORDS; gi++) begin : g_word
      waea_word u_word (
        .clk      (clk),
        .nrst     (nrst),
        .erase_en (commit && op_mode_q == waea_pkg::MODE_ERASE &&
                   op_addr_q == waea_pkg::ADDR_W'(gi)),
        .write_en (commit && op_mode_q == waea_pkg::MODE_WRITE &&
                   op_addr_q == waea_pkg::ADDR_W'(gi)),
        .wdata    (op_data_q),
        .word_q   (word_q[gi]),
        .valid_q  (valid_q[gi])
      );
    end
  endgenerate

  assign data_out   = dout_q;
  assign data_oe_n  = oe_n_q;
  assign power_down = pd_q;
  assign alter_busy = busy_q;
  assign data_undef = undef_q;

endmodule : waea_top
`default_nettype wire

//--- test/waea_host.sv
/*
  Host-side view of the shared data pins.
  Assumes the pins are resolved only from data_out and data_oe_n.
*/
`timescale 1ns/10ps
`default_nettype none
module waea_host (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output logic      [7:0] bus
);
  logic [7:0] last_q = 8'h00;
  // floated pins show the inverse of the last driven byte, never stale data
  always_comb bus = data_oe_n ? ~last_q : data_out;
  // remember the byte that the device last drove
  always @(posedge clk) begin
    if (!data_oe_n) begin
      last_q <= data_out;
    end
  end
endmodule : waea_host
`default_nettype wire

//--- test/waea_props.sv
/*
  Checker on the pins of the memory access block.
  Assumes a single clock domain and reset released synchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module waea_props #(
  parameter int ALTER_CYC = 20
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic cs_hi,
  input  wire logic cs_lo_n,
  input  wire logic mode_c1,
  input  wire logic rd_clk,
  input  wire logic data_oe_n,
  input  wire logic power_down,
  input  wire logic alter_busy
);
  logic sel;
  // decoded chip select
  assign sel = cs_hi && !cs_lo_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_float_desel: assert property (!sel |=> data_oe_n)
    else $error("pins driven while deselected");
  a_power_sel: assert property (sel |=> !power_down)
    else $error("power reduced while selected");
  a_alter_desel: assert property (!sel |=> !alter_busy)
    else $error("alteration runs while deselected");
  a_busy_cause: assert property ($rose(alter_busy)
    |-> $past(sel) && !$past(mode_c1))
    else $error("alteration began outside erase or write");
  a_read_lat: assert property ($fell(data_oe_n)
    |-> $past(rd_clk, 81) && !$past(rd_clk, 82))
    else $error("read data not 80 cycles after pulse");
  a_read_hold: assert property (!data_oe_n && sel && mode_c1
    |=> !data_oe_n)
    else $error("read data dropped in read mode");
  a_mode_drop: assert property (!data_oe_n && sel && !mode_c1
    |=> data_oe_n)
    else $error("read data kept after mode change");
  a_busy_abort: assert property (alter_busy && sel && mode_c1
    |=> !alter_busy)
    else $error("alteration kept after mode change");
  int busy_run_q;
  // consecutive cycles with the alteration flag up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_run_q <= 0;
    end else begin
      busy_run_q <= alter_busy ? busy_run_q + 1 : 0;
    end
  end
  a_busy_len: assert property (alter_busy
    |-> busy_run_q < ALTER_CYC)
    else $error("alteration flag held past its cycle");
  c_read: cover property ($fell(data_oe_n));
  c_alter: cover property ($fell(alter_busy));
  c_abort: cover property (alter_busy && !sel);
endmodule : waea_props
bind waea_top waea_props #(.ALTER_CYC(ALTER_CYC)) waea_props_inst (
  .clk, .nrst, .cs_hi, .cs_lo_n, .mode_c1, .rd_clk, .data_oe_n,
  .power_down, .alter_busy);
`default_nettype wire

//--- test/tb_top.sv
/*
  Self-checking bench of the memory access block.
  Assumes a shortened alteration cycle and the host bus model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int ALT = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_hi = 1'b0;
  logic cs_lo_n = 1'b1;
  logic mode_c1 = 1'b1;
  logic mode_c2 = 1'b0;
  logic rd_clk = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out;
  logic [7:0] bus;
  logic data_oe_n, power_down, alter_busy, data_undef;
  int n_errors = 0;
  int n_tests = 0;
  logic [5:0] adrs [3] = '{6'h00, 6'h3f, 6'h05};
  waea_top #(.ALTER_CYC(ALT)) waea_top_inst (.clk, .nrst, .cs_hi,
    .cs_lo_n, .mode_c1, .mode_c2, .rd_clk, .addr, .data_in, .data_out,
    .data_oe_n, .power_down, .alter_busy, .data_undef);
  waea_host waea_host_inst (.clk, .data_out, .data_oe_n, .bus);
  // free-running clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic final_report;
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic drive(input logic s, c1, c2, rc, input logic [5:0] a,
                       input logic [7:0] d);
    @(negedge clk);
    {cs_hi, cs_lo_n, mode_c1, mode_c2, rd_clk} = {s, !s, c1, c2, rc};
    {addr, data_in} = {a, d};
  endtask : drive
  task automatic wait_busy(input logic v);
    for (int i = 0; i < ALT + 9 && alter_busy !== v; i++) @(negedge clk);
    check(alter_busy, v);
  endtask : wait_busy
  // mode change first, so each alteration starts on a fresh edge
  task automatic alter(input logic c2, input logic [5:0] a,
                       input logic [7:0] d);
    drive(1'b1, 1'b1, 1'b0, 1'b0, a, d);
    drive(1'b1, 1'b0, c2, 1'b0, a, d);
    wait_busy(1'b1);
    repeat (ALT - 1) @(negedge clk);
    check(alter_busy, 1'b1);
    @(negedge clk);
    check(alter_busy, 1'b0);
    wait_busy(1'b0);
    repeat (4) @(negedge clk);
    check(alter_busy, 1'b0);
  endtask : alter
  task automatic read(input logic c2, input logic [5:0] a,
                      input logic [7:0] e, input logic u);
    drive(1'b1, 1'b1, c2, 1'b0, a, 8'h00);
    drive(1'b1, 1'b1, c2, 1'b1, a, 8'h00);
    drive(1'b1, 1'b1, c2, 1'b0, a, 8'h00);
    for (int i = 0; i < 100 && data_oe_n !== 1'b0; i++) @(negedge clk);
    check(data_oe_n, 1'b0);
    if (!u) check(bus, e);
    check(data_undef, u);
  endtask : read
  // watchdog
  initial begin
    #250000;
    n_errors++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    check(power_down, 1'b1);
    check(data_oe_n, 1'b1);
    foreach (adrs[k]) begin
      alter(1'b1, adrs[k], 8'hff);
      alter(1'b0, adrs[k], 8'hc3 ^ {2'h0, adrs[k]});
      read(adrs[k][0], adrs[k], 8'hc3 ^ {2'h0, adrs[k]}, 1'b0);
    end
    drive(1'b1, 1'b1, 1'b1, 1'b0, 6'h05, 8'h00);
    repeat (10) @(negedge clk);
    check(bus, 8'hc6);
    drive(1'b0, 1'b1, 1'b1, 1'b0, 6'h05, 8'h00);
    repeat (2) @(negedge clk);
    check(data_oe_n, 1'b1);
    check(power_down, 1'b1);
    drive(1'b0, 1'b0, 1'b0, 1'b0, 6'h05, 8'h3c);
    repeat (30) @(negedge clk);
    check(alter_busy, 1'b0);
    drive(1'b1, 1'b1, 1'b0, 1'b0, 6'h05, 8'h00);
    drive(1'b1, 1'b0, 1'b1, 1'b0, 6'h05, 8'h00);
    repeat (5) @(negedge clk);
    drive(1'b0, 1'b0, 1'b1, 1'b0, 6'h05, 8'h00);
    repeat (30) @(negedge clk);
    read(1'b0, 6'h05, 8'hc6, 1'b0);
    alter(1'b1, 6'h09, 8'h00);
    read(1'b1, 6'h09, 8'h00, 1'b1);
    drive(1'b1, 1'b0, 1'b1, 1'b0, 6'h09, 8'h00);
    repeat (5) @(negedge clk);
    check(data_oe_n, 1'b1);
    drive(1'b1, 1'b1, 1'b1, 1'b0, 6'h09, 8'h00);
    repeat (2) @(negedge clk);
    check(alter_busy, 1'b0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
